//--- hw/asw_ctrl.sv
// Purpose: Host-side controller driving an asynchronous byte-wide SRAM
// Assumes: One request at a time; pins are registered straight to pads
// Notes:   Each write is setup, pulse, recovery under one chosen control
`timescale 1ns/100ps
module asw_ctrl
    import asw_pkg::*;
#(
    parameter bit SLEEP_FITTED = 1'b1
) (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              clock_enable,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire asw_mode_e         req_mode,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_data,
    input  wire logic              standby,
    output logic                   req_ready,
    output logic                   wr_done,
    output logic      [DATA_W-1:0] rd_data,
    output logic                   rd_valid,
    output logic      [ADDR_W-1:0] sram_addr,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe,
    input  wire logic [DATA_W-1:0] data_in,
    output logic                   write_strobe_n,
    output logic                   chip_select_n,
    output logic                   sleep_n,
    output logic                   output_enable_n
);
    // ========================================================
    // Control word helpers
    // Gap word keeps only the governing control idle
    function automatic asw_ctrl_t write_ctrl(input asw_mode_e mode,
                                             input logic active);
        asw_ctrl_t c;
        c = CTRL_WRITE;
        if (!active) begin
            unique case (mode)
                MODE_STROBE: c = CTRL_GAP_STROBE;
                MODE_SELECT: c = CTRL_GAP_SELECT;
                MODE_SLEEP:  c = CTRL_GAP_SLEEP;
                default:     c = CTRL_GAP_STROBE;
            endcase
        end
        return c;
    endfunction

    // Without sleep fitted, sleep-mode writes fall back to the strobe
    function automatic asw_mode_e pick_mode(input asw_mode_e mode);
        asw_mode_e m;
        m = mode;
        if (!SLEEP_FITTED && mode == MODE_SLEEP) begin
            m = MODE_STROBE;
        end
        if (mode != MODE_STROBE && mode != MODE_SELECT &&
            mode != MODE_SLEEP) begin
            m = MODE_STROBE;
        end
        return m;
    endfunction

    localparam asw_regs_s REGS_RESET = '{
        state:   ST_IDLE,
        count:   CNT_ZERO,
        mode:    MODE_STROBE,
        addr:    '0,
        wdata:   '0,
        data_oe: 1'b0,
        ctrl:    CTRL_IDLE,
        oe_n:    1'b1,
        ready:   1'b1,
        done:    1'b0,
        rdata:   '0,
        rvalid:  1'b0
    };

    asw_regs_s         r;
    asw_regs_s         next_r;
    logic [DATA_W-1:0] data_sync;
    asw_ctrl_t         idle_ctrl;

    asw_sync u_sync (
        .clock        (clock),
        .clock_enable (clock_enable),
        .reset        (reset),
        .pin_in       (data_in),
        .sync_out     (data_sync)
    );

    // Standby parks the memory in sleep between requests
    assign idle_ctrl = (SLEEP_FITTED && standby) ? CTRL_NAP : CTRL_IDLE;

    // ========================================================
    // Sequencer
    always_comb begin
        next_r        = r;
        next_r.done   = 1'b0;
        next_r.rvalid = 1'b0;
        unique case (r.state)
            ST_IDLE: begin
                next_r.ctrl    = idle_ctrl;
                next_r.oe_n    = 1'b1;
                next_r.data_oe = 1'b0;
                if (req_valid && r.ready) begin
                    // Address and data settle before the write enabling edge; a read enables on the same edge as its address
                    next_r.addr  = req_addr;
                    next_r.wdata = req_data;
                    if (req_write) begin
                        next_r.mode    = pick_mode(req_mode);
                        next_r.state   = ST_SETUP;
                        next_r.count   = SETUP_CYC - CNT_ONE;
                        next_r.data_oe = 1'b1;
                        next_r.ctrl    = write_ctrl(pick_mode(req_mode),
                                                    1'b0);
                    end else begin
                        next_r.state = ST_READ;
                        next_r.count = READ_CYC - CNT_ONE;
                        next_r.ctrl  = CTRL_READ;
                        next_r.oe_n  = 1'b0;
                    end
                end
            end
            ST_SETUP: begin
                if (r.count == CNT_ZERO) begin
                    next_r.state = ST_PULSE;
                    next_r.count = PULSE_CYC - CNT_ONE;
                    next_r.ctrl  = write_ctrl(r.mode, 1'b1);
                end else begin
                    next_r.count = r.count - CNT_ONE;
                end
            end
            ST_PULSE: begin
                // Pulse covers both width and data setup to the end edge
                if (r.count == CNT_ZERO) begin
                    next_r.state = ST_RECOVER;
                    next_r.count = REC_CYC - CNT_ONE;
                    next_r.ctrl  = write_ctrl(r.mode, 1'b0);
                end else begin
                    next_r.count = r.count - CNT_ONE;
                end
            end
            ST_RECOVER: begin
                // Address and data held through recovery
                if (r.count == CNT_ZERO) begin
                    next_r.state   = ST_IDLE;
                    next_r.done    = 1'b1;
                    next_r.data_oe = 1'b0;
                    next_r.ctrl    = idle_ctrl;
                end else begin
                    next_r.count = r.count - CNT_ONE;
                end
            end
            ST_READ: begin
                // Wait covers access time plus the synchroniser
                if (r.count == CNT_ZERO) begin
                    next_r.state  = ST_IDLE;
                    next_r.rdata  = data_sync;
                    next_r.rvalid = 1'b1;
                    next_r.ctrl   = idle_ctrl;
                    next_r.oe_n   = 1'b1;
                end else begin
                    next_r.count = r.count - CNT_ONE;
                end
            end
            default: begin
                next_r = REGS_RESET;
            end
        endcase
        if (!SLEEP_FITTED) begin
            next_r.ctrl[0] = 1'b1;
        end
        next_r.ready = (next_r.state == ST_IDLE);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            r <= REGS_RESET;
        end else if (clock_enable) begin
            r <= next_r;
        end
    end

    // ========================================================
    // Outputs, all straight from the state flops
    assign req_ready       = r.ready;
    assign wr_done         = r.done;
    assign rd_data         = r.rdata;
    assign rd_valid        = r.rvalid;
    assign sram_addr       = r.addr;
    assign data_out        = r.wdata;
    assign data_oe         = r.data_oe;
    assign write_strobe_n  = r.ctrl[2];
    assign chip_select_n   = r.ctrl[1];
    assign sleep_n         = r.ctrl[0];
    assign output_enable_n = r.oe_n;

    // ========================================================
    // Checks on the pins this controller drives
    logic write_on;
    assign write_on = !r.ctrl[2] && !r.ctrl[1] && r.ctrl[0];

    a_ctrl_gap:
    assert property (@(posedge clock) disable iff (reset)
        $fell(write_on) |-> !write_on ##1 !write_on)
    else $error("write controls not released between writes");

    a_addr_setup:
    assert property (@(posedge clock) disable iff (reset)
        $rose(write_on) |-> $stable(r.addr) && $past(r.state) == ST_SETUP)
    else $error("address changed at write enabling edge");

    a_addr_hold:
    assert property (@(posedge clock) disable iff (reset)
        $fell(write_on) |-> $stable(r.addr) ##1 $stable(r.addr))
    else $error("address not held past write end");

    a_data_window:
    assert property (@(posedge clock) disable iff (reset)
        write_on |-> r.data_oe && $past(r.data_oe) && $stable(r.wdata))
    else $error("write data not valid through pulse");

    a_data_hold:
    assert property (@(posedge clock) disable iff (reset)
        $fell(write_on) |-> r.data_oe && $stable(r.wdata))
    else $error("write data dropped at write end");

    a_cycle_spacing:
    assert property (@(posedge clock) disable iff (reset)
        $rose(write_on) && clock_enable |=> !$rose(write_on) ##1
        !$rose(write_on))
    else $error("write cycles closer than minimum cycle");

    a_no_sleep_pin:
    assert property (@(posedge clock) disable iff (reset)
        !SLEEP_FITTED |-> r.ctrl[0])
    else $error("sleep driven low on non-sleep variant");

    a_read_strobe:
    assert property (@(posedge clock) disable iff (reset)
        !r.oe_n |-> r.ctrl[2] && !r.data_oe)
    else $error("output enable asserted during write");

endmodule

//--- common/asw_pkg.sv
// Purpose: Constants and types for the asynchronous SRAM write controller
// Assumes: 50 MHz clock; slowest (worst-case) memory timing is used
// Notes:   All pin timing is built from whole clock cycles
package asw_pkg;

    // ========================================================
    // Widths
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 4;
    localparam int SYNC_STAGES = 2;

    // ========================================================
    // Timing, ns as printed (worst-case column)
    localparam int CLK_PERIOD_NS           = 20;
    localparam int T_WRITE_PULSE_NS        = 20;
    localparam int DATA_SETUP_TO_WRITE_END = 15;
    localparam int T_RECOVERY_NS           = 5;
    localparam int MIN_CYCLE_TIME          = 25;
    localparam int T_READ_ACCESS_NS        = 25;

    // Least times round up, never below one cycle
    function automatic int cyc_up(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int PULSE_INT = (cyc_up(T_WRITE_PULSE_NS) >
                                cyc_up(DATA_SETUP_TO_WRITE_END)) ?
                               cyc_up(T_WRITE_PULSE_NS) :
                               cyc_up(DATA_SETUP_TO_WRITE_END);
    localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(1);
    localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'(PULSE_INT);
    localparam logic [CNT_W-1:0] REC_CYC   = CNT_W'(cyc_up(T_RECOVERY_NS));
    localparam logic [CNT_W-1:0] CYCLE_CYC = CNT_W'(cyc_up(MIN_CYCLE_TIME));
    localparam logic [CNT_W-1:0] READ_CYC  =
        CNT_W'(cyc_up(T_READ_ACCESS_NS) + SYNC_STAGES);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    // ========================================================
    // Types
    typedef enum logic [1:0] {
        MODE_STROBE,
        MODE_SELECT,
        MODE_SLEEP
    } asw_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_PULSE,
        ST_RECOVER,
        ST_READ
    } asw_state_e;

    // Pin control word: {write_strobe_n, chip_select_n, sleep_n}
    typedef logic [2:0] asw_ctrl_t;
    localparam asw_ctrl_t CTRL_WRITE = 3'h1;
    localparam asw_ctrl_t CTRL_READ  = 3'h5;
    localparam asw_ctrl_t CTRL_IDLE  = 3'h7;
    localparam asw_ctrl_t CTRL_NAP   = 3'h6;
    localparam asw_ctrl_t CTRL_GAP_STROBE = 3'h5;
    localparam asw_ctrl_t CTRL_GAP_SELECT = 3'h3;
    localparam asw_ctrl_t CTRL_GAP_SLEEP  = 3'h0;

    typedef struct packed {
        asw_state_e          state;
        logic [CNT_W-1:0]    count;
        asw_mode_e           mode;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic                data_oe;
        asw_ctrl_t           ctrl;
        logic                oe_n;
        logic                ready;
        logic                done;
        logic [DATA_W-1:0]   rdata;
        logic                rvalid;
    } asw_regs_s;

endpackage

//--- hw/asw_sync.sv
// Purpose: Two-stage synchroniser for the memory's read data pins
// Assumes: Pins change only while the controller waits out access time
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module asw_sync
    import asw_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              clock_enable,
    input  wire logic [DATA_W-1:0] pin_in,
    output logic      [DATA_W-1:0] sync_out
);
    // ========================================================
    // Per-bit flop pairs
    genvar i;
    generate
        for (i = 0; i < DATA_W; i++) begin : g_bit
            logic meta;
            logic held;
            always_ff @(posedge clock) begin
                if (reset) begin
                    meta <= 1'b0;
                    held <= 1'b0;
                end else if (clock_enable) begin
                    meta <= pin_in[i];
                    held <= meta;
                end
            end
            assign sync_out[i] = held;
        end
    endgenerate
endmodule

//--- verification/asw_sram_model.sv
// Purpose: Behavioural byte-wide asynchronous SRAM on the controller pins
// Assumes: Controller pins move only at its clock edges
// Notes:   Pin-timing faults are counted, not fatal
`timescale 1ns/100ps
module asw_sram_model
    import asw_pkg::*;
#(
    parameter bit SLEEP_FITTED = 1'b1
) (
    input  wire logic [ADDR_W-1:0] sram_addr,
    input  wire logic [DATA_W-1:0] pin_bus,
    input  wire logic              write_strobe_n,
    input  wire logic              chip_select_n,
    input  wire logic              sleep_n,
    input  wire logic              output_enable_n,
    output logic      [DATA_W-1:0] dq_out,
    output int                     write_count,
    output int                     fault_count
);
    logic [DATA_W-1:0] mem [int];
    logic [ADDR_W-1:0] w_addr;
    logic [DATA_W-1:0] last_drv;
    logic              in_write;
    realtime           t_start;
    realtime           t_end;
    realtime           t_data;
    realtime           t_addr;
    // ========================================================
    // Qualification
    // Without the option the pin is absent, so it reads as awake
    wire sleep_eff = SLEEP_FITTED ? sleep_n : 1'b1;
    // Last control in opens, first out closes, same for all three
    wire wr_act = !write_strobe_n && !chip_select_n && sleep_eff;
    // Asleep the decode is off, so nothing is driven
    wire rd_act = !chip_select_n && !output_enable_n && sleep_eff
                  && write_strobe_n;
    initial begin
        write_count = 0;
        fault_count = 0;
        in_write = 1'b0;
        t_start = -1000.0;
        t_end = -1000.0;
        t_data = 0.0;
        t_addr = 0.0;
        last_drv = 8'h00;
    end
    // ========================================================
    // Write cycle
    always @(posedge wr_act) begin
        if ($realtime - t_end < T_RECOVERY_NS) fault_count++;
        if ($realtime - t_start < MIN_CYCLE_TIME) fault_count++;
        if ($realtime == t_addr) fault_count++;
        t_start = $realtime;
        w_addr = sram_addr;
        in_write = 1'b1;
    end
    always @(negedge wr_act) begin
        if (in_write) begin
            in_write = 1'b0;
            if ($realtime - t_data < DATA_SETUP_TO_WRITE_END)
                fault_count++;
            mem[int'(w_addr)] = pin_bus;
            write_count++;
            t_end = $realtime;
        end
    end
    always @(sram_addr) begin
        if (in_write) fault_count++;
        t_addr = $realtime;
    end
    always @(pin_bus) begin
        if (!in_write && $realtime == t_end) fault_count++;
        t_data = $realtime;
    end
    // ========================================================
    // Read drive; released lines show the inverse of the last byte
    always @(rd_act, sram_addr, write_count) begin
        if (rd_act) begin
            dq_out = mem.exists(int'(sram_addr)) ?
                     mem[int'(sram_addr)] : 8'h00;
            last_drv = dq_out;
        end else begin
            dq_out = ~last_drv;
        end
    end
endmodule

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the SRAM write controller
// Assumes: Write answers three enabled edges after take, read four
// Notes:   Each scenario is one task; the memory model flags pin faults
`timescale 1ns/100ps
`define CHK(what, exp, got) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end \
end
module tb_top;
    import asw_pkg::*;
    logic              clock = 1'b0;
    logic              reset = 1'b1;
    logic              clock_enable = 1'b1;
    logic              req_valid = 1'b0;
    logic              req_write = 1'b0;
    asw_mode_e         req_mode = MODE_STROBE;
    logic [ADDR_W-1:0] req_addr = 19'h0;
    logic [DATA_W-1:0] req_data = 8'h00;
    logic              standby = 1'b0;
    logic              req_ready, wr_done, rd_valid, data_oe;
    logic [DATA_W-1:0] rd_data, data_out, dq_out, q;
    logic [ADDR_W-1:0] sram_addr;
    logic              write_strobe_n, chip_select_n;
    logic              sleep_n, output_enable_n;
    wire  [DATA_W-1:0] pin_bus = data_oe ? data_out : dq_out;
    int                write_count, fault_count, wc;
    int                num_errors = 0;
    int                check_count = 0;
    always #10 clock = ~clock;
    asw_ctrl i_dut (.clock(clock), .reset(reset),
        .clock_enable(clock_enable), .req_valid(req_valid),
        .req_write(req_write), .req_mode(req_mode), .req_addr(req_addr),
        .req_data(req_data), .standby(standby), .req_ready(req_ready),
        .wr_done(wr_done), .rd_data(rd_data), .rd_valid(rd_valid),
        .sram_addr(sram_addr), .data_out(data_out), .data_oe(data_oe),
        .data_in(pin_bus), .write_strobe_n(write_strobe_n),
        .chip_select_n(chip_select_n), .sleep_n(sleep_n),
        .output_enable_n(output_enable_n));
    asw_sram_model i_mem (.sram_addr(sram_addr), .pin_bus(pin_bus),
        .write_strobe_n(write_strobe_n), .chip_select_n(chip_select_n),
        .sleep_n(sleep_n), .output_enable_n(output_enable_n),
        .dq_out(dq_out), .write_count(write_count),
        .fault_count(fault_count));
    // ========================================================
    // Shared tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Counts falling edges from the take edge; answer shows one falling
    // edge after the last enabled edge of the transfer
    task automatic wait_ans(input logic wr);
        int   n;
        int   exp_n;
        logic seen;
        n = 0;
        seen = 1'b0;
        exp_n = wr ? int'(SETUP_CYC + PULSE_CYC + REC_CYC) + 1 :
                     int'(READ_CYC) + 1;
        while (!seen && n < 12) begin
            @(negedge clock);
            n++;
            seen = wr ? (wr_done === 1'b1) : (rd_valid === 1'b1);
        end
        `CHK("answer cycle", exp_n, n)
        if (!seen) finish_test();
    endtask
    task automatic put_req(input logic wr, input int m,
                           input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d);
        req_valid <= 1'b1;
        req_write <= wr;
        req_mode <= asw_mode_e'(m[1:0]);
        req_addr <= a;
        req_data <= d;
    endtask
    task automatic xfer(input logic wr, input int m,
                        input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
        put_req(wr, m, a, d);
        @(posedge clock);
        req_valid <= 1'b0;
        wait_ans(wr);
        q = rd_data;
        @(posedge clock);
    endtask
    // ========================================================
    // Scenarios
    task automatic test_reset();
        @(negedge clock);
        `CHK("idle pins", 8'hf4, {write_strobe_n, chip_select_n, sleep_n,
             output_enable_n, data_oe, req_ready, wr_done, rd_valid})
        @(posedge clock);
        $display("test reset done");
    endtask
    task automatic test_modes();
        for (int m = 0; m < 4; m++) begin
            wc = write_count;
            xfer(1'b1, m, 19'h40000 | 19'(m), 8'ha5 ^ 8'(m));
            `CHK("write count", wc + 1, write_count)
        end
        for (int m = 0; m < 4; m++) begin
            xfer(1'b0, 0, 19'h40000 | 19'(m), 8'h00);
            `CHK("read back", 8'ha5 ^ 8'(m), q)
        end
        $display("test modes done");
    endtask
    // Second request held while busy: ignored, then taken in done cycle
    task automatic test_back();
        wc = write_count;
        put_req(1'b1, 1, 19'h7ffff, 8'h3c);
        @(posedge clock);
        put_req(1'b1, 2, 19'h00000, 8'hc3);
        wait_ans(1'b1);
        @(posedge clock);
        req_valid <= 1'b0;
        wait_ans(1'b1);
        @(posedge clock);
        `CHK("write count", wc + 2, write_count)
        xfer(1'b0, 0, 19'h7ffff, 8'h00);
        `CHK("read top", 8'h3c, q)
        xfer(1'b0, 0, 19'h00000, 8'h00);
        `CHK("read bottom", 8'hc3, q)
        $display("test back done");
    endtask
    task automatic test_freeze();
        put_req(1'b1, 0, 19'h12345, 8'h77);
        @(posedge clock);
        req_valid <= 1'b0;
        clock_enable <= 1'b0;
        repeat (3) @(posedge clock);
        clock_enable <= 1'b1;
        wait_ans(1'b1);
        @(posedge clock);
        $display("test freeze done");
    endtask
    task automatic test_standby();
        standby <= 1'b1;
        repeat (3) @(posedge clock);
        @(negedge clock);
        `CHK("sleep pin", 1'b0, sleep_n)
        @(posedge clock);
        standby <= 1'b0;
        repeat (3) @(posedge clock);
        xfer(1'b0, 0, 19'h12345, 8'h00);
        `CHK("read after sleep", 8'h77, q)
        $display("test standby done");
    endtask
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        test_reset();
        test_modes();
        test_back();
        test_freeze();
        test_standby();
        `CHK("pin faults", 0, fault_count)
        finish_test();
    end
endmodule
